// ---- ros_cfg_defines.vh ----
`ifndef ROS_CFG_DEFINES_VH
`define ROS_CFG_DEFINES_VH

// register addresses (5-bit address field of the instruction)
`define ROS_ADDR_IO_DIR        5'h06
`define ROS_ADDR_REF_OSC       5'h07
`define ROS_ADDR_SER_CFG       5'h18

// instruction byte fields
`define ROS_INS_DIRECT_BIT     7
`define ROS_INS_READ_BIT       6
`define ROS_INS_ADDR_MSB       4

// direction register layout
`define ROS_IO_DIR_MASK        8'h0F
`define ROS_IO_DIR_RESET       8'h00

// reference/oscillator register layout
`define ROS_REF_OSC_MASK       8'h3F
`define ROS_REF_OSC_RESET      8'h00
`define ROS_BIT_CLK_SRC        5
`define ROS_BIT_OSC_EN         4
`define ROS_BIT_REF_EN         3
`define ROS_BIT_BUF_EN         2
`define ROS_BIT_REF_LEVEL      1
`define ROS_BIT_BANDGAP        0

// serial config register layout, each control mirrored about the centre
`define ROS_SER_CFG_MASK       8'hE7
`define ROS_SER_CFG_RESET      8'h00
`define ROS_BIT_LSB_HI         7
`define ROS_BIT_2W_HI          6
`define ROS_BIT_EARLY_HI       5
`define ROS_BIT_EARLY_LO       2
`define ROS_BIT_2W_LO          1
`define ROS_BIT_LSB_LO         0

// reference level codes on reference_level_code
`define ROS_VREF_2V5           2'h0
`define ROS_VREF_2V048         2'h1
`define ROS_VREF_1V15          2'h2

// oscillator timing
`define ROS_SYS_FREQ_KHZ       25000
`define ROS_OSC_FREQ_KHZ       2500
`define ROS_OSC_HALF_CYC       (`ROS_SYS_FREQ_KHZ / (2 * `ROS_OSC_FREQ_KHZ))

`endif

// ---- ros_sync.v ----
`default_nettype none

// three-stage synchroniser; the output moves only when stages two and three agree
module ros_sync (
    // clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // asynchronous level in, settled level out
    input  wire async_in,
    output reg  sync_out
);

    reg stage1;  // metastability catcher, read only by stage2
    reg stage2;  // second stage
    reg stage3;  // third stage

    // shift chain plus agreement filter
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1   <= 1'b0;
            stage2   <= 1'b0;
            stage3   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // a change counts only once two stages agree
            if (stage2 == stage3) begin
                sync_out <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// ---- ros_cfg.v ----
// Contract
// - clock source bit picks oscillator or divided conversion clock (pin, or oscillator when enabled)
// - oscillator enable drives clock pin, else input
// - source and reference enable also run oscillator
// - pin or register bits run oscillator; reset zero
// - reference enable powers reference, default off
// - buffer enable powers buffer, default off
// - bandgap overrides level bit; level picks 2.5/2.048
// - direction bits make io pins outputs
// - mirrored serial control bits, either activates
// - serial control sets order, wires, release
// - bit order bit selects lsb first
// - two wire mode drives data input pin
// - early release frees pin on last edge
`include "ros_cfg_defines.vh"
`default_nettype none

module ros_cfg #(
    parameter DIV_W = 3  // conversion clock divider width, up to divide by 8
) (
    // clock and reset
    input  wire       clk_sys,
    input  wire       rst_n,
    // serial interface pins
    input  wire       serial_clk,
    input  wire       chip_select_n,
    input  wire       din_in,
    output reg        din_out,
    output reg        din_oe,
    output reg        dout_out,
    output reg        dout_oe,
    // conversion clock pin, two-way
    input  wire       conversion_clock_pin_in,
    output reg        conversion_clock_pin_out,
    output reg        conversion_clock_pin_oe,
    // oscillator enable pin
    input  wire       pin_a,
    // clock divide field from the converter control register
    input  wire [1:0] clock_divide,
    // analog controls
    output reg        ref_clock,
    output reg        osc_running,
    output reg        reference_power_enable,
    output reg        ref_buffer_power_enable,
    output reg  [1:0] reference_level_code,
    output reg  [3:0] io_direction
);

    // one-hot serial states
    localparam [3:0] ST_INSTR = 4'h1;  // receiving instruction byte
    localparam [3:0] ST_WDATA = 4'h2;  // receiving write data
    localparam [3:0] ST_RDATA = 4'h4;  // sending read data
    localparam [3:0] ST_DONE  = 4'h8;  // frame spent, wait for deselect

    localparam integer OSC_HALF_CNT = `ROS_OSC_HALF_CYC - 1;  // toggle point
    localparam [2:0]   OSC_HALF     = OSC_HALF_CNT[2:0];      // cut to counter width

    // register contents
    reg  [7:0] digital_io_direction;         // address 6
    reg  [7:0] reference_oscillator_config;  // address 7
    reg  [7:0] serial_interface_config;      // address 24

    // settled pin levels
    wire       sclk_s;    // serial clock
    wire       cs_n_s;    // chip select, active low
    wire       din_s;     // serial data in
    wire       conversion_clock_pin_s;    // conversion clock pin
    wire       pin_a_s;   // oscillator enable pin
    wire       cs_n_raw;  // selected level, inverted so reset reads deselected
    reg        sclk_q;    // previous serial clock
    reg        cs_n_q;    // previous chip select

    // serial engine
    reg  [3:0] state;     // one-hot state
    reg  [2:0] bit_cnt;   // bits seen in current byte
    reg  [7:0] rx_sh;     // receive shifter
    reg  [7:0] tx_sh;     // transmit shifter
    reg  [4:0] addr;      // addressed register
    reg  [7:0] next_rx;   // receive shifter with the new bit
    reg  [7:0] read_val;  // readback of addressed register

    // oscillator and divider
    reg  [2:0]       osc_cnt;  // half period counter
    reg              osc_clk;  // modelled internal oscillator
    reg              conv_q;   // previous conversion clock
    reg  [DIV_W-1:0] div_cnt;  // conversion clock divider
    reg              div_clk;  // divided conversion clock

    // decoded controls, each serial function active if either mirror bit is set
    wire lsb_first   = serial_interface_config[`ROS_BIT_LSB_HI]
                     | serial_interface_config[`ROS_BIT_LSB_LO];
    wire two_wire    = serial_interface_config[`ROS_BIT_2W_HI]
                     | serial_interface_config[`ROS_BIT_2W_LO];
    wire early_rel   = serial_interface_config[`ROS_BIT_EARLY_HI]
                     | serial_interface_config[`ROS_BIT_EARLY_LO];
    wire clk_src_osc = reference_oscillator_config[`ROS_BIT_CLK_SRC];
    wire osc_en_bit  = reference_oscillator_config[`ROS_BIT_OSC_EN];
    wire ref_en_bit  = reference_oscillator_config[`ROS_BIT_REF_EN];

    // edges of the settled serial pins
    wire sclk_rise  = sclk_s & ~sclk_q;   // active edge
    wire sclk_fall  = ~sclk_s & sclk_q;   // inactive edge
    wire cs_release = cs_n_s & ~cs_n_q;   // deselect
    wire last_bit   = (bit_cnt == 3'h7);  // eighth active edge
    wire conv_clk   = osc_en_bit ? osc_clk : conversion_clock_pin_s;
    wire conv_rise  = conv_clk & ~conv_q;

    // oscillator runs on pin, enable bit, or reference clocking needs
    wire osc_on = pin_a_s | osc_en_bit | (clk_src_osc & ref_en_bit);

    // synchronisers for every pin from outside
    ros_sync u_sync_sclk (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (serial_clk),
        .sync_out (sclk_s)
    );
    ros_sync u_sync_cs (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (~chip_select_n),
        .sync_out (cs_n_raw)
    );
    assign cs_n_s = ~cs_n_raw;  // back to active-low sense
    ros_sync u_sync_din (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (din_in),
        .sync_out (din_s)
    );
    ros_sync u_sync_conversion_clock_pin (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (conversion_clock_pin_in),
        .sync_out (conversion_clock_pin_s)
    );
    ros_sync u_sync_pin_a (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (pin_a),
        .sync_out (pin_a_s)
    );

    // receive shift and readback mux
    always @* begin
        // bit order applies to every byte in and out
        if (lsb_first) begin
            next_rx = {din_s, rx_sh[7:1]};
        end else begin
            next_rx = {rx_sh[6:0], din_s};
        end
        // reserved bits are masked so they always read zero
        case (next_rx[`ROS_INS_ADDR_MSB:0])
            `ROS_ADDR_IO_DIR:  read_val = digital_io_direction & `ROS_IO_DIR_MASK;
            `ROS_ADDR_REF_OSC: read_val = reference_oscillator_config
                                        & `ROS_REF_OSC_MASK;
            `ROS_ADDR_SER_CFG: read_val = serial_interface_config
                                        & `ROS_SER_CFG_MASK;
            default:           read_val = 8'h00;
        endcase
    end

    // serial engine: instruction, register write or register read
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state                       <= ST_INSTR;
            bit_cnt                     <= 3'h0;
            rx_sh                       <= 8'h00;
            tx_sh                       <= 8'h00;
            addr                        <= 5'h00;
            sclk_q                      <= 1'b0;
            cs_n_q                      <= 1'b1;
            dout_out                    <= 1'b0;
            dout_oe                     <= 1'b0;
            din_out                     <= 1'b0;
            din_oe                      <= 1'b0;
            digital_io_direction        <= `ROS_IO_DIR_RESET;
            reference_oscillator_config <= `ROS_REF_OSC_RESET;
            serial_interface_config     <= `ROS_SER_CFG_RESET;
        end else begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
            if (cs_n_s) begin
                // deselect ends any frame and always frees the data pins
                state   <= ST_INSTR;
                bit_cnt <= 3'h0;
                if (cs_release) begin
                    dout_oe <= 1'b0;
                    din_oe  <= 1'b0;
                end
            end else if (sclk_rise) begin
                rx_sh   <= next_rx;
                bit_cnt <= bit_cnt + 3'h1;
                case (state)
                    ST_INSTR: begin
                        // only register-mode instructions are acted on here
                        if (last_bit) begin
                            addr <= next_rx[`ROS_INS_ADDR_MSB:0];
                            if (next_rx[`ROS_INS_DIRECT_BIT]) begin
                                state <= ST_DONE;
                            end else if (next_rx[`ROS_INS_READ_BIT]) begin
                                tx_sh <= read_val;
                                state <= ST_RDATA;
                            end else begin
                                state <= ST_WDATA;
                            end
                        end
                    end
                    ST_WDATA: begin
                        // reserved bits are dropped on write
                        if (last_bit) begin
                            state <= ST_DONE;
                            case (addr)
                                `ROS_ADDR_IO_DIR:  digital_io_direction <=
                                    next_rx & `ROS_IO_DIR_MASK;
                                `ROS_ADDR_REF_OSC: reference_oscillator_config <=
                                    next_rx & `ROS_REF_OSC_MASK;
                                `ROS_ADDR_SER_CFG: serial_interface_config <=
                                    next_rx & `ROS_SER_CFG_MASK;
                                default: ;
                            endcase
                        end
                    end
                    ST_RDATA: begin
                        // eighth active edge of the data byte ends the read
                        if (last_bit) begin
                            state <= ST_DONE;
                            if (early_rel) begin
                                dout_oe <= 1'b0;
                                din_oe  <= 1'b0;
                            end
                        end
                    end
                    ST_DONE: begin
                        // extra clocks after the byte are ignored
                        bit_cnt <= 3'h0;
                    end
                    default: state <= ST_INSTR;
                endcase
            end else if (sclk_fall) begin
                if (state == ST_RDATA) begin
                    // present the next bit on the inactive edge
                    dout_oe  <= 1'b1;
                    din_oe   <= two_wire;
                    dout_out <= lsb_first ? tx_sh[0] : tx_sh[7];
                    din_out  <= lsb_first ? tx_sh[0] : tx_sh[7];
                    tx_sh    <= lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
                end else if (state == ST_DONE) begin
                    // normal release waits for the inactive edge
                    dout_oe <= 1'b0;
                    din_oe  <= 1'b0;
                end
            end
        end
    end

    // internal oscillator model, a divided system clock
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            osc_cnt <= 3'h0;
            osc_clk <= 1'b0;
        end else if (!osc_on) begin
            // powered down: parked low so no stray edge appears
            osc_cnt <= 3'h0;
            osc_clk <= 1'b0;
        end else if (osc_cnt == OSC_HALF) begin
            osc_cnt <= 3'h0;
            osc_clk <= ~osc_clk;
        end else begin
            osc_cnt <= osc_cnt + 3'h1;
        end
    end

    // conversion clock divider, counted on conversion clock rises
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            conv_q  <= 1'b0;
            div_cnt <= {DIV_W{1'b0}};
            div_clk <= 1'b0;
        end else begin
            conv_q <= conv_clk;
            if (conv_rise) begin
                div_cnt <= div_cnt + 1'b1;
            end
            // divide by 1, 2, 4 or 8
            case (clock_divide)
                2'h0:    div_clk <= conv_clk;
                2'h1:    div_clk <= div_cnt[0];
                2'h2:    div_clk <= div_cnt[1];
                default: div_clk <= div_cnt[2];
            endcase
        end
    end

    // analog-facing controls; register outputs keep the pins glitch free
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ref_clock                <= 1'b0;
            osc_running              <= 1'b0;
            conversion_clock_pin_out <= 1'b0;
            conversion_clock_pin_oe  <= 1'b0;
            reference_power_enable   <= 1'b0;
            ref_buffer_power_enable  <= 1'b0;
            reference_level_code     <= `ROS_VREF_2V5;
            io_direction             <= 4'h0;
        end else begin
            ref_clock                <= clk_src_osc ? osc_clk : div_clk;
            osc_running              <= osc_on;
            conversion_clock_pin_out <= osc_clk;
            conversion_clock_pin_oe  <= osc_en_bit;
            reference_power_enable   <= ref_en_bit;
            ref_buffer_power_enable  <=
                reference_oscillator_config[`ROS_BIT_BUF_EN];
            // bandgap select wins over the level bit
            if (reference_oscillator_config[`ROS_BIT_BANDGAP]) begin
                reference_level_code <= `ROS_VREF_1V15;
            end else if (reference_oscillator_config[`ROS_BIT_REF_LEVEL]) begin
                reference_level_code <= `ROS_VREF_2V048;
            end else begin
                reference_level_code <= `ROS_VREF_2V5;
            end
            io_direction <= digital_io_direction[3:0];
        end
    end

endmodule

`default_nettype wire

// ---- ros_cfg_properties.sv ----
`default_nettype none

// watches the pins and configuration outputs of the block
module ros_cfg_properties (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // serial and oscillator pins
    input wire logic       chip_select_n,
    input wire logic       pin_a,
    input wire logic       din_out,
    input wire logic       din_oe,
    input wire logic       dout_out,
    input wire logic       dout_oe,
    input wire logic       conversion_clock_pin_out,
    input wire logic       osc_running,
    // configuration outputs
    input wire logic       reference_power_enable,
    input wire logic       ref_buffer_power_enable,
    input wire logic [1:0] reference_level_code,
    input wire logic [3:0] io_direction
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cs_hi_cnt; // cycles with chip select high, saturating

    // counts how long the frame has been closed
    always @(posedge clk_sys) begin
        if (!rst_n || !chip_select_n) begin
            cs_hi_cnt <= 4'h0;
        end else if (cs_hi_cnt != 4'hF) begin
            cs_hi_cnt <= cs_hi_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_rst_vals;
        $rose(rst_n) |-> io_direction == 4'h0 && !reference_power_enable
            && !ref_buffer_power_enable && reference_level_code == 2'h0 && !osc_running;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("outputs not cleared by reset");

    // a write only lands while a frame is open
    property p_cfg_quiet;
        $changed({io_direction, reference_power_enable, ref_buffer_power_enable,
            reference_level_code}) |-> cs_hi_cnt < 4'h5;
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet)
        else $error("configuration moved outside a frame");

    property p_dout_quiet;
        cs_hi_cnt > 4'h6 |-> !dout_oe && !din_oe;
    endproperty
    a_dout_quiet: assert property (p_dout_quiet)
        else $error("data pin still driven after chip select rose");

    property p_din_mirror;
        din_oe |-> dout_oe && din_out == dout_out;
    endproperty
    a_din_mirror: assert property (p_din_mirror)
        else $error("two-wire data differs from dout");

    property p_pin_osc;
        pin_a [*7] |-> osc_running;
    endproperty
    a_pin_osc: assert property (p_pin_osc)
        else $error("oscillator off with enable pin high");

    // 2.5 MHz from 25 MHz: five cycles high, ten per period
    property p_osc_high;
        $rose(conversion_clock_pin_out) |=> (conversion_clock_pin_out || !osc_running) [*4];
    endproperty
    a_osc_high: assert property (p_osc_high)
        else $error("oscillator high phase too short");

    property p_osc_per;
        $rose(conversion_clock_pin_out) |-> ##10 ($rose(conversion_clock_pin_out) || !osc_running);
    endproperty
    a_osc_per: assert property (p_osc_per)
        else $error("oscillator period not ten cycles");

    property p_lvl;
        reference_level_code != 2'h3;
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("illegal reference level code");

    c_two_wire: cover property (din_oe);
    c_osc: cover property ($rose(osc_running));
    c_io_all: cover property (io_direction == 4'hF);
endmodule

bind ros_cfg ros_cfg_properties chk_u (.*);

`default_nettype wire

// ---- ros_host_model.sv ----
`default_nettype none

// host controller on the serial pins; bit order chosen per call
module ros_host_model (
    // clock
    input wire logic  clk_sys,
    // answers from the device
    input wire logic  dout_out,
    input wire logic  dout_oe,
    input wire logic  din_in,
    // serial pins
    output var logic  serial_clk,
    output var logic  chip_select_n,
    output var logic  din_drv
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: deselected, clock parked low
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        din_drv = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one frame: instruction byte then one data byte
    task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input logic lsb,
        output logic [7:0] rd, output logic mir, output logic [1:0] oe);
        int k;
        mir = 1'b1;
        rd = 8'h00;
        chip_select_n = 1'b0;
        hw(8);
        for (int i = 0; i < 16; i++) begin
            k = lsb ? i % 8 : 7 - i % 8;
            if (i < 8 || !ins[6]) begin
                din_drv = i < 8 ? ins[k] : dat[k];
            end else begin
                din_drv = ~din_drv; // released line wanders
            end
            hw(8);
            if (i >= 8) begin
                rd[k] = dout_oe ? dout_out : ~dout_out; // released line shows garbage
                if (din_in !== dout_out) mir = 1'b0;
            end
            serial_clk = 1'b1;
            hw(7);
            if (i == 15) oe[1] = dout_oe;
            hw(1);
            serial_clk = 1'b0;
            hw(8);
        end
        oe[0] = dout_oe;
        chip_select_n = 1'b1;
        din_drv = ~din_drv;
        hw(12);
    endtask
endmodule

`default_nettype wire

// ---- testbench.sv ----
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [4:0] adr;
        logic [7:0] wd;
        logic [7:0] rb;
        logic [3:0] io;
        logic [1:0] pwr;
        logic [1:0] lvl;
    } ros_row_t;

    logic       clk_sys;
    logic       rst_n;
    logic       pin_a;
    logic [1:0] clock_divide;
    logic [2:0] cc_cnt = 3'h0; // pin clock divider, period eight
    logic       lsb_on;     // host bit order
    logic [7:0] rdv;
    logic       mir;
    logic [1:0] oe2;
    int         fail_count;
    int         checks_done;
    wire logic  serial_clk, chip_select_n, din_drv, din_in, din_out, din_oe, dout_out, dout_oe;
    wire logic  cc_pin, conversion_clock_pin_out, conversion_clock_pin_oe, ref_clock;
    wire logic  osc_running, reference_power_enable, ref_buffer_power_enable;
    wire logic [1:0] reference_level_code;
    wire logic [3:0] io_direction;

    // write, readback, then {io, ref, buf, level}
    ros_row_t rows [7] = '{
        '{5'h06, 8'hFF, 8'h0F, 4'hF, 2'h0, 2'h0}, '{5'h06, 8'h05, 8'h05, 4'h5, 2'h0, 2'h0},
        '{5'h07, 8'h0A, 8'h0A, 4'h5, 2'h2, 2'h1}, '{5'h07, 8'hC7, 8'h07, 4'h5, 2'h1, 2'h2},
        '{5'h07, 8'h0C, 8'h0C, 4'h5, 2'h3, 2'h0}, '{5'h18, 8'h18, 8'h00, 4'h5, 2'h3, 2'h0},
        '{5'h09, 8'hFF, 8'h00, 4'h5, 2'h3, 2'h0}};
    logic [7:0] codes [6] = '{8'h01, 8'h80, 8'h02, 8'h40, 8'h04, 8'h20};

    // two-way pins resolved from both parties
    assign din_in = din_oe ? din_out : din_drv;
    assign cc_pin = conversion_clock_pin_oe ? conversion_clock_pin_out : cc_cnt[2];

    ros_cfg dut_u (.clk_sys, .rst_n, .serial_clk, .chip_select_n, .din_in, .din_out, .din_oe,
        .dout_out, .dout_oe, .conversion_clock_pin_in(cc_pin), .conversion_clock_pin_out,
        .conversion_clock_pin_oe, .pin_a, .clock_divide, .ref_clock, .osc_running,
        .reference_power_enable, .ref_buffer_power_enable, .reference_level_code,
        .io_direction);

    ros_host_model host_u (.clk_sys, .dout_out, .dout_oe, .din_in, .serial_clk,
        .chip_select_n, .din_drv);

    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;
    always @(negedge clk_sys) cc_cnt <= cc_cnt + 3'h1;

    task automatic end_sim;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic rd, input logic [4:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, rd, 1'b0, a}, d, lsb_on, rdv, mir, oe2);
    endtask

    // counts rising edges of the pin or reference clock
    task automatic rate(input int n, input logic sel, input logic [7:0] exp);
        logic p;
        int c;
        c = 0;
        repeat (70) @(negedge clk_sys);
        p = sel ? cc_pin : ref_clock;
        repeat (n) begin
            @(negedge clk_sys);
            if (!p && (sel ? cc_pin : ref_clock)) c++;
            p = sel ? cc_pin : ref_clock;
        end
        chk(c[7:0], exp);
    endtask

    task automatic wait_osc(input logic v);
        int w;
        w = 0;
        while (osc_running !== v && w < 20) begin
            @(negedge clk_sys);
            w++;
        end
        if (osc_running !== v) begin
            fail_count++;
            end_sim();
        end
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end

    initial begin
        rst_n = 1'b0;
        pin_a = 1'b0;
        clock_divide = 2'h0;
        lsb_on = 1'b0;
        fail_count = 0;
        checks_done = 0;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({io_direction, reference_power_enable, ref_buffer_power_enable,
            reference_level_code}, 8'h00);
        chk({6'h00, osc_running, conversion_clock_pin_oe}, 8'h00);
        foreach (codes[j]) begin
            acc(1'b1, j < 2 ? 5'h06 : j < 4 ? 5'h07 : 5'h18, 8'h00);
            chk(rdv, 8'h00);
        end
        foreach (rows[i]) begin
            acc(1'b0, rows[i].adr, rows[i].wd);
            acc(1'b1, rows[i].adr, 8'h00);
            chk(rdv, rows[i].rb);
            chk({io_direction, reference_power_enable, ref_buffer_power_enable,
                reference_level_code}, {rows[i].io, rows[i].pwr, rows[i].lvl});
        end
        // oscillator and reference clock sources
        acc(1'b0, 5'h07, 8'h10);
        chk({6'h00, osc_running, conversion_clock_pin_oe}, 8'h03);
        rate(200, 1'b1, 8'h14);
        acc(1'b0, 5'h07, 8'h00);
        chk({6'h00, osc_running, conversion_clock_pin_oe}, 8'h00);
        acc(1'b0, 5'h07, 8'h28);
        chk({6'h00, osc_running, conversion_clock_pin_oe}, 8'h02);
        rate(200, 1'b0, 8'h14);
        acc(1'b0, 5'h07, 8'h20);
        chk({6'h00, osc_running, conversion_clock_pin_oe}, 8'h00);
        acc(1'b0, 5'h07, 8'h08);
        for (int d = 0; d < 4; d++) begin
            clock_divide = d[1:0];
            rate(160 << d, 1'b0, 8'h14);
        end
        pin_a = 1'b1;
        wait_osc(1'b1);
        chk({7'h00, osc_running}, 8'h01);
        pin_a = 1'b0;
        wait_osc(1'b0);
        // each mirrored serial control bit alone
        foreach (codes[j]) begin
            acc(1'b0, 5'h18, codes[j]);
            lsb_on = codes[j][0] | codes[j][7];
            acc(1'b0, 5'h06, 8'h03);
            acc(1'b1, 5'h06, 8'h00);
            chk(rdv, 8'h03);
            acc(1'b1, 5'h18, 8'h00);
            chk(rdv, codes[j]);
            chk({6'h00, oe2}, |(codes[j] & 8'h24) ? 8'h00 : 8'h02);
            if (|(codes[j] & 8'h42)) chk({7'h00, mir}, 8'h01);
            acc(1'b0, 5'h18, 8'h00);
            lsb_on = 1'b0;
        end
        end_sim();
    end
endmodule

`default_nettype wire
